// ===== src/thermal_pkg.sv
// Shared constants and types for the thermal status serial frame block.
package thermal_pkg;

	// Channel and word geometry.
	localparam int CH_N   = 3;
	localparam int WORD_W = 16;
	localparam int CNT_W  = 4;
	localparam int DRV_W  = 2 * CH_N;

	// Layout of the synchronised pin vector.
	localparam int P_CS   = 0;
	localparam int P_SCLK = 1;
	localparam int P_SI   = 2;
	localparam int P_WARN = 3;
	localparam int P_SHUT = P_WARN + CH_N;
	localparam int PIN_W  = P_SHUT + CH_N;

	// Field positions in the diagnostic and command words.
	localparam int FLAG_BIT         = 0;
	localparam int STATUS_RESET_BIT = 0;
	localparam int DRV_LSB          = 1;

	// Reset and idle values.
	localparam logic [CNT_W-1:0]  CNT_ZERO  = 4'h0;
	localparam logic [CNT_W-1:0]  CNT_ONE   = 4'h1;
	localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
	localparam logic [DRV_W-1:0]  DRV_OFF   = 6'h00;
	// Idle pins: chip select high, serial clock low, so no false edge follows reset.
	localparam logic [PIN_W-1:0]  PIN_IDLE  = 9'h001;

	// Frame tracking states, one-hot.
	typedef enum logic [1:0]
	{
		ST_IDLE  = 2'b01,
		ST_FRAME = 2'b10
	} frame_state_t;

endpackage

// ===== src/pin_sync.sv
// Two-flop synchroniser for the pins that arrive from outside the clock domain.
`timescale 1ns/1ps
module pin_sync
(
	input  wire logic                         i_mclk,
	input  wire logic                         i_reset,
	input  wire logic [thermal_pkg::PIN_W-1:0] i_pins,
	output logic      [thermal_pkg::PIN_W-1:0] o_pins
);

	logic [thermal_pkg::PIN_W-1:0] meta;

	// The first stage feeds only the second; idle pins reset to chip select high.
	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
		begin
			meta   <= thermal_pkg::PIN_IDLE;
			o_pins <= thermal_pkg::PIN_IDLE;
		end
		else
		begin
			meta   <= i_pins;
			o_pins <= meta;
		end
	end

endmodule

// ===== src/thermal_status_serial_frame.sv
// Thermal warning and shutdown latches with the serial frame that reports them.
// Behaviour
// - Three independent monitors, one per channel, each with warning and shutdown levels.
// - Any warning level sets the warning flag; only status reset after cooling clears.
// - A warning alone never turns any driver off.
// - Shutdown level latches all drivers off; cooled turn-on with status reset re-enables.
// - Warning flag is diagnostic bit 0 and stays set until status reset.
// - Chip select falling with input low puts the warning bit on output at once.
// - Early output is low without warning and high with warning.
// - Early level holds while serial clock is static; clocking shifts further bits.
// - First 16 bits shifted out after chip select falls are the diagnostic word.
// - Serial data is accepted only while this chip select is low.
`timescale 1ns/1ps
module thermal_status_serial_frame
(
	input  wire logic                             i_mclk,
	input  wire logic                             i_reset,
	input  wire logic                             i_chip_select_n,
	input  wire logic                             i_sclk,
	input  wire logic                             i_si,
	input  wire logic [thermal_pkg::CH_N-1:0]     i_temp_warn,
	input  wire logic [thermal_pkg::CH_N-1:0]     i_temp_shut,
	input  wire logic [thermal_pkg::WORD_W-1:1]   i_diag_other,
	output logic                                  o_so,
	output logic                                  o_so_oe,
	output logic                                  o_thermal_warn_flag,
	output logic                                  o_shutdown,
	output logic      [thermal_pkg::DRV_W-1:0]    o_drive_on,
	output logic      [thermal_pkg::WORD_W-1:0]   o_command,
	output logic                                  o_frame_done,
	output logic                                  o_frame_error
);

	// True when any bit of a monitor vector is raised.
	function automatic logic any_hot(input logic [thermal_pkg::CH_N-1:0] v);
		any_hot = |v;
	endfunction

	// Driver request field of a command word.
	function automatic logic [thermal_pkg::DRV_W-1:0] drv_field
	(
		input logic [thermal_pkg::WORD_W-1:0] w
	);
		drv_field = w[thermal_pkg::DRV_LSB +: thermal_pkg::DRV_W];
	endfunction

	logic [thermal_pkg::PIN_W-1:0]  pins;
	logic                           cs_n;
	logic                           sclk;
	logic                           si;
	logic [thermal_pkg::CH_N-1:0]   warn;
	logic [thermal_pkg::CH_N-1:0]   shut;
	logic                           cs_prev;
	logic                           sclk_prev;
	logic                           cs_fall;
	logic                           cs_rise;
	logic                           sclk_rise;
	logic                           sclk_fall;
	logic                           warn_any;
	logic                           shut_any;
	thermal_pkg::frame_state_t      state;
	logic                           si_bit;
	logic [thermal_pkg::WORD_W-1:0] rx;
	logic [thermal_pkg::WORD_W-1:0] tx;
	logic [thermal_pkg::WORD_W-1:0] next_tx;
	logic [thermal_pkg::CNT_W-1:0]  bit_cnt;
	logic                           got_bits;
	logic                           frame_end;
	logic                           frame_ok;
	logic                           status_reset_request;
	logic                           next_shutdown;
	logic [thermal_pkg::DRV_W-1:0]  next_drive;

	// All pins, including the analog monitor levels, cross into the clock domain.
	pin_sync u_pin_sync
	(
		.i_mclk  (i_mclk),
		.i_reset (i_reset),
		.i_pins  ({i_temp_shut, i_temp_warn, i_si, i_sclk, i_chip_select_n}),
		.o_pins  (pins)
	);

	// Named views of the synchronised pins.
	assign cs_n = pins[thermal_pkg::P_CS];
	assign sclk = pins[thermal_pkg::P_SCLK];
	assign si   = pins[thermal_pkg::P_SI];
	assign warn = pins[thermal_pkg::P_WARN +: thermal_pkg::CH_N];
	assign shut = pins[thermal_pkg::P_SHUT +: thermal_pkg::CH_N];

	// Each channel has its own pair of levels; any one of them is enough.
	assign warn_any = any_hot(warn);
	assign shut_any = any_hot(shut);

	// Edge history of the synchronised chip select and serial clock.
	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
		begin
			cs_prev   <= 1'b1;
			sclk_prev <= 1'b0;
		end
		else
		begin
			cs_prev   <= cs_n;
			sclk_prev <= sclk;
		end
	end

	// Clock edges count only while this device is selected.
	assign cs_fall   = cs_prev & ~cs_n;
	assign cs_rise   = ~cs_prev & cs_n;
	assign sclk_rise = ~sclk_prev & sclk & ~cs_n & (state == thermal_pkg::ST_FRAME);
	assign sclk_fall = sclk_prev & ~sclk & ~cs_n & (state == thermal_pkg::ST_FRAME);

	// Frame tracking between chip select edges.
	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
			state <= thermal_pkg::ST_IDLE;
		else
		begin
			unique case (state)
				thermal_pkg::ST_IDLE:
					if (cs_fall)
						state <= thermal_pkg::ST_FRAME;
				thermal_pkg::ST_FRAME:
					if (cs_rise)
						state <= thermal_pkg::ST_IDLE;
				default:
					state <= thermal_pkg::ST_IDLE;
			endcase
		end
	end

	// Input bits are sampled on rising serial clock edges, first bit ending at bit 0.
	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
		begin
			si_bit <= 1'b0;
			rx     <= thermal_pkg::WORD_ZERO;
		end
		else if (sclk_rise)
		begin
			si_bit <= si;
			rx     <= {si, rx[thermal_pkg::WORD_W-1:1]};
		end
	end

	// The counter wraps at a word, so zero with bits seen means a whole multiple.
	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
		begin
			bit_cnt  <= thermal_pkg::CNT_ZERO;
			got_bits <= 1'b0;
		end
		else if (cs_fall)
		begin
			bit_cnt  <= thermal_pkg::CNT_ZERO;
			got_bits <= 1'b0;
		end
		else if (sclk_rise)
		begin
			bit_cnt  <= bit_cnt + thermal_pkg::CNT_ONE;
			got_bits <= 1'b1;
		end
	end

	// A frame is acted on only when its length is a whole multiple of a word.
	assign frame_end            = cs_rise & (state == thermal_pkg::ST_FRAME);
	assign frame_ok             = frame_end & got_bits & (bit_cnt == thermal_pkg::CNT_ZERO);
	assign status_reset_request = rx[thermal_pkg::STATUS_RESET_BIT];

	// Outgoing shift register: diagnostic word at select, chained input behind it.
	always_comb
	begin
		next_tx = tx;
		if (cs_fall)
			next_tx = {i_diag_other, o_thermal_warn_flag};
		else if (sclk_fall)
			next_tx = {si_bit, tx[thermal_pkg::WORD_W-1:1]};
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
			tx <= thermal_pkg::WORD_ZERO;
		else
			tx <= next_tx;
	end

	// The output bit follows the head of the shift register, so it only moves on
	// select or on a falling serial clock and holds while the clock is static.
	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
			o_so <= 1'b0;
		else
			o_so <= next_tx[thermal_pkg::FLAG_BIT];
	end

	// The output is driven only while selected, so parallel outputs never fight.
	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
			o_so_oe <= 1'b0;
		else
			o_so_oe <= ~cs_n;
	end

	// Warning latch: set wins over a clear that lands in the same cycle, and a
	// still-hot channel keeps it set, so clearing implies the part has cooled.
	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
			o_thermal_warn_flag <= 1'b0;
		else if (warn_any)
			o_thermal_warn_flag <= 1'b1;
		else if (frame_ok && status_reset_request)
			o_thermal_warn_flag <= 1'b0;
	end

	// Shutdown latch clears only on a cooled, valid turn-on frame carrying reset.
	always_comb
	begin
		next_shutdown = o_shutdown;
		if (shut_any)
			next_shutdown = 1'b1;
		else if (frame_ok && status_reset_request && (drv_field(rx) != thermal_pkg::DRV_OFF))
			next_shutdown = 1'b0;
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
			o_shutdown <= 1'b0;
		else
			o_shutdown <= next_shutdown;
	end

	// Last accepted command; a discarded frame leaves it untouched.
	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
			o_command <= thermal_pkg::WORD_ZERO;
		else if (frame_ok)
			o_command <= rx;
	end

	// Drivers follow the command; only the shutdown latch masks them, never warning.
	always_comb
	begin
		next_drive = frame_ok ? drv_field(rx) : drv_field(o_command);
		if (next_shutdown)
			next_drive = thermal_pkg::DRV_OFF;
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
			o_drive_on <= thermal_pkg::DRV_OFF;
		else
			o_drive_on <= next_drive;
	end

	// One-cycle pulses reporting how each frame ended.
	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
		begin
			o_frame_done  <= 1'b0;
			o_frame_error <= 1'b0;
		end
		else
		begin
			o_frame_done  <= frame_ok;
			o_frame_error <= frame_end & ~frame_ok;
		end
	end

	// Checks on the behaviour above.
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_reset);

	AST_WARN_SETS: assert property (warn_any |=> o_thermal_warn_flag)
		else $error("Warning level did not set the warning flag.");

	AST_WARN_STICKY: assert property (
		o_thermal_warn_flag && !(frame_ok && status_reset_request) |=> o_thermal_warn_flag)
		else $error("Warning flag dropped without a status reset.");

	AST_SHUT_OFF: assert property (
		shut_any |=> o_shutdown && (o_drive_on == thermal_pkg::DRV_OFF))
		else $error("Shutdown level did not turn all drivers off.");

	AST_SHUT_LATCH: assert property (o_shutdown && !frame_ok |=> o_shutdown)
		else $error("Shutdown latch released without a turn-on frame.");

	AST_WARN_KEEPS_ON: assert property (
		frame_ok && !next_shutdown |=> o_drive_on == drv_field(o_command))
		else $error("Drivers did not follow the command outside shutdown.");

	AST_EARLY_SO: assert property (
		cs_fall |=> o_so_oe && (o_so == $past(o_thermal_warn_flag)))
		else $error("Warning bit not shown at chip select fall.");

	AST_SO_HOLD: assert property (
		o_so_oe && !cs_fall && !sclk_fall |=> $stable(o_so))
		else $error("Serial output moved without a clock edge.");

	AST_DIAG_WORD: assert property (
		cs_fall |=> tx[thermal_pkg::WORD_W-1:1] == $past(i_diag_other))
		else $error("Diagnostic word not loaded at chip select fall.");

	AST_HIZ: assert property (cs_n |=> !o_so_oe)
		else $error("Serial output driven while deselected.");

	AST_DESELECT: assert property (cs_n |=> $stable(rx))
		else $error("Serial data taken while deselected.");

	AST_BAD_FRAME: assert property (
		frame_end && !frame_ok |=> o_frame_error && $stable(o_command) && !o_frame_done)
		else $error("Odd-length frame was not discarded.");

	COV_FRAME_OK: cover property (frame_ok ##1 o_frame_done);
	COV_FRAME_BAD: cover property (frame_end && !frame_ok);
	COV_SHUT_CLEAR: cover property (o_shutdown ##1 !o_shutdown);
	COV_WARN_CLEAR: cover property (o_thermal_warn_flag ##1 !o_thermal_warn_flag);

endmodule

// ===== verification/serial_master_model.sv
// Serial master model that frames commands and collects the status word.
`timescale 1ns/1ps
module serial_master_model
(
	input  wire logic i_mclk,
	input  wire logic i_so,
	output logic      o_cs_n,
	output logic      o_sclk,
	output logic      o_si
);
	// Idle state is deselected with the clock low.
	initial
	begin
		o_cs_n = 1'b1;
		o_sclk = 1'b0;
		o_si   = 1'b1;
	end

	// Pins move only on falling clock edges, away from the sampling edge.
	task automatic gap(input int n);
		repeat (n) @(negedge i_mclk);
	endtask

	// Select with data low and leave the serial clock static.
	task automatic select();
		gap(1);
		o_si   = 1'b0;
		o_cs_n = 1'b0;
		gap(8);
	endtask

	// Released data shows the inverse level, so a stale bit cannot pass for a real one.
	task automatic release_cs();
		o_cs_n = 1'b1;
		o_si   = ~o_si;
		gap(8);
	endtask

	// Shift LSB first, sampling the output at each rising clock edge.
	task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
		rx = 32'h00000000;
		select();
		for (int i = 0; i < n; i++)
		begin
			o_si   = tx[i];
			gap(8);
			o_sclk = 1'b1;
			rx[i]  = i_so;
			gap(8);
			o_sclk = 1'b0;
		end
		gap(8);
		release_cs();
	endtask

	// Clock and data wiggle while deselected.
	task automatic noise();
		repeat (8)
		begin
			o_sclk = ~o_sclk;
			o_si   = ~o_si;
			gap(8);
		end
	endtask
endmodule

// ===== verification/thermal_status_serial_frame_bench.sv
// Self-checking bench for the thermal status serial frame block.
`timescale 1ns/1ps
module thermal_status_serial_frame_bench;
	typedef struct packed {logic err; logic [15:0] cmd; logic flag; logic [5:0] drv;} note_t;
	logic        i_mclk = 1'b0, i_reset = 1'b1, cs_n, sclk, si, so, so_oe;
	logic        flag, shut, done, ferr, got_err, e_flag = 1'b0, e_shut = 1'b0;
	logic [2:0]  warn = 3'h0, hot = 3'h0;
	logic [15:1] diag = 15'h0000;
	logic [5:0]  drv;
	logic [15:0] cmd, e_cmd = 16'h0000;
	logic [31:0] rx;
	note_t       notes[$], nt;
	integer      seed = 32'h22a13f8f;
	int          bad_count = 0, tests_run = 0, cycles = 0;

	// The clock runs at 100 MHz.
	initial
		forever #5 i_mclk = ~i_mclk;

	serial_master_model mst (.i_mclk(i_mclk), .i_so(so), .o_cs_n(cs_n), .o_sclk(sclk), .o_si(si));

	thermal_status_serial_frame dut_u (.i_mclk(i_mclk), .i_reset(i_reset),
		.i_chip_select_n(cs_n), .i_sclk(sclk), .i_si(si), .i_temp_warn(warn),
		.i_temp_shut(hot), .i_diag_other(diag), .o_so(so), .o_so_oe(so_oe),
		.o_thermal_warn_flag(flag), .o_shutdown(shut), .o_drive_on(drv), .o_command(cmd),
		.o_frame_done(done), .o_frame_error(ferr));

	// Comparisons count every check and report each mismatch at once.
	task automatic check_bit(input string what, input logic e, input logic g);
		tests_run++;
		if (g !== e)
		begin
			bad_count++;
			$display("wrong value %s expected %b seen %b", what, e, g);
		end
	endtask

	task automatic check_word(input string what, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e)
		begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Work out the frame outcome before sending it, then check the shifted-out bits.
	task automatic frame(input int n, input logic [31:0] tx);
		logic        ok;
		logic        f;
		logic [15:0] c;
		ok = (n % 16 == 0) && (n > 0);
		c  = ok ? 16'(tx >> (n - 16)) : e_cmd;
		f  = e_flag;
		if (ok)
		begin
			e_cmd = c;
			if (c[0])
				e_flag = |warn;
			if (c[0] && |c[6:1] && !(|hot))
				e_shut = 1'b0;
		end
		notes.push_back('{!ok, e_cmd, e_flag, e_shut ? 6'h00 : e_cmd[6:1]});
		diag = 15'($random(seed));
		mst.xfer(n, tx, rx);
		if (n >= 16)
			check_word("diag word", {diag, f}, rx[15:0]);
		if (n == 32)
			check_word("chained bits", tx[15:0], rx[31:16]);
	endtask

	// Select without clocking: a zero-bit frame that must be refused.
	task automatic early();
		notes.push_back('{1'b1, e_cmd, e_flag, e_shut ? 6'h00 : e_cmd[6:1]});
		mst.select();
		check_bit("early enable", 1'b1, so_oe);
		check_bit("early level", e_flag, so);
		mst.gap(24);
		check_bit("held level", e_flag, so);
		mst.release_cs();
		check_bit("released enable", 1'b0, so_oe);
	endtask

	// Each frame pulse takes the oldest note; flags settle with the pulse and are checked two cycles later.
	initial
		forever
		begin
			@(negedge i_mclk);
			if (done === 1'b1 || ferr === 1'b1)
			begin
				got_err = ferr;
				mst.gap(2);
				nt = (notes.size() > 0) ? notes.pop_front() : 'x;
				check_bit("frame error", nt.err, got_err);
				check_word("command", nt.cmd, cmd);
				check_bit("warning flag", nt.flag, flag);
				check_word("drivers", {10'h000, nt.drv}, {10'h000, drv});
			end
		end

	// A hang is cut short well above the expected length of the run.
	always @(posedge i_mclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			bad_count++;
			results();
		end
	end

	// Main sequence.
	initial
	begin
		repeat (5) @(negedge i_mclk);
		i_reset = 1'b0;
		diag    = 15'($random(seed));
		mst.gap(4);
		check_bit("reset enable", 1'b0, so_oe);
		early();
		for (int ch = 0; ch < 3; ch++)
		begin
			warn     = 3'($random(seed)) | (3'h1 << ch);
			e_flag   = 1'b1;
			mst.gap(8);
			check_bit("flag set", 1'b1, flag);
			early();
			frame(16, 32'($random(seed)) & 32'h007e);
			warn = 3'h0;
			frame(15, 32'h0001);
			frame(16, 32'($random(seed)) & 32'h007e);
			frame(16, 32'h0001 | (32'($random(seed)) & 32'h007e));
		end
		hot    = 3'($random(seed)) | 3'h2;
		e_shut = 1'b1;
		mst.gap(8);
		check_bit("shutdown", 1'b1, shut);
		check_word("drivers off", 16'h0000, {10'h000, drv});
		frame(16, 32'h007f);
		hot = 3'h0;
		frame(16, 32'h003e);
		frame(16, 32'h0001);
		frame(16, 32'h007f);
		check_bit("shutdown cleared", 1'b0, shut);
		frame(32, 32'($random(seed)));
		mst.noise();
		mst.gap(16);
		check_word("ignored command", e_cmd, cmd);
		results();
	end
endmodule
